/* rtl/fmhs_top.sv */
// Fault monitor, interrupt source and high side switch control
`timescale 1ns/1ps
`include "fmhs_params.svh"
module fmhs_top #(
   parameter int unsigned TXD_STUCK_CYC = `FMHS_TXD_STUCK_MS * `FMHS_CLK_KHZ,
   parameter int unsigned NR_TIMEOUT_CYC = `FMHS_NR_TIMEOUT_MS * `FMHS_CLK_KHZ,
   parameter int unsigned WD_INT_CYC = `FMHS_WD_INT_MS * `FMHS_CLK_KHZ,
   parameter int unsigned WD_EXT_CYC = `FMHS_WD_EXT_MS * `FMHS_CLK_KHZ,
   parameter int unsigned RST_HOLD_CYC = `FMHS_RST_HOLD_MS * `FMHS_CLK_KHZ
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Operating mode from the mode logic
   input wire fmhs_pkg::fmhs_mode_type mode_i,
   // Register port
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [3:0] reg_wdata_i,
   output logic [3:0] reg_rdata_o,
   // Supply and regulator monitors
   input wire logic supply_over_voltage_i,
   input wire logic supply_under_voltage_i,
   input wire logic battery_fail_i,
   input wire logic regulator_prewarn_i,
   input wire logic regulator_overheat_i,
   input wire logic regulator_under_voltage_i,
   // LIN monitors and transmitter pins
   input wire logic receive_pin_short_i,
   input wire logic lin_driver_overheat_i,
   input wire logic lin_txd_i,
   output logic lin_tx_enable_o,
   // High side monitors and pins
   input wire logic high_side_overheat_i,
   input wire logic output_one_open_load_i,
   input wire logic output_two_open_load_i,
   input wire logic output_one_current_limit_i,
   input wire logic output_two_current_limit_i,
   input wire logic direct_pwm_input_i,
   output logic output_one_on_o,
   output logic output_two_on_o,
   // Watchdog
   input wire logic watchdog_config_pin_floating_i,
   // Host side outputs
   output logic irq_n_o,
   output logic [3:0] interrupt_source_o,
   output logic host_reset_o,
   output logic regulator_disable_o,
   output logic goto_sleep_o
);

   localparam int W = `FMHS_CNT_W;

   fmhs_pkg::fmhs_state_type q, d;
   logic [15:0] pins_async;
   logic [15:0] pins;

   // ==================================================================
   // Pin synchronisation
   assign pins_async = {supply_over_voltage_i, supply_under_voltage_i, battery_fail_i,
      regulator_prewarn_i, regulator_overheat_i, regulator_under_voltage_i,
      receive_pin_short_i, lin_driver_overheat_i, lin_txd_i, high_side_overheat_i,
      output_one_open_load_i, output_two_open_load_i, output_one_current_limit_i,
      output_two_current_limit_i, direct_pwm_input_i, watchdog_config_pin_floating_i};

   fmhs_sync #(
      .W(16)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .async_i(pins_async),
      .sync_o(pins)
   );

   logic ov, uv, battery_fail_flag, prewarn, reg_ot, vdd_uv;
   logic rx_short, lin_ot, txd, hs_ot, ol1, ol2, cl1, cl2, pwm, wd_float;
   assign {ov, uv, battery_fail_flag, prewarn, reg_ot, vdd_uv, rx_short, lin_ot, txd, hs_ot,
      ol1, ol2, cl1, cl2, pwm, wd_float} = pins;

   // ==================================================================
   // Helpers
   function automatic logic hit(input logic [3:0] a, input logic [3:0] k);
      hit = (a == k);
   endfunction

   function automatic logic [3:0] src_code(input logic [2:0] f);
      if (f[`FMHS_IMR_HS_BIT]) begin
         src_code = `FMHS_CODE_HS;
      end else if (f[`FMHS_IMR_LIN_BIT]) begin
         src_code = `FMHS_CODE_LIN;
      end else if (f[`FMHS_IMR_SUPPLY_BIT]) begin
         src_code = `FMHS_CODE_SUPPLY;
      end else begin
         src_code = `FMHS_CODE_NONE;
      end
   endfunction

   // ==================================================================
   // Next state
   always_comb begin
      logic act;
      logic low_pwr;
      logic irq_ok;
      logic wr_high_side_control;
      logic wr_mcr;
      logic wr_imr;
      logic rd_lin;
      logic rd_wd;
      logic rd_isr;
      logic vs_ev;
      logic lin_ev;
      logic hs_ev;
      logic lin_fault;
      logic tx_stuck;
      logic wd_fault;
      logic nr_fault;
      logic [W-1:0] wd_per;
      logic [2:0] ev;
      logic [1:0] want;
      act = 1'b0;
      low_pwr = 1'b0;
      irq_ok = 1'b0;
      wr_high_side_control = 1'b0;
      wr_mcr = 1'b0;
      wr_imr = 1'b0;
      rd_lin = 1'b0;
      rd_wd = 1'b0;
      rd_isr = 1'b0;
      vs_ev = 1'b0;
      lin_ev = 1'b0;
      hs_ev = 1'b0;
      lin_fault = 1'b0;
      tx_stuck = 1'b0;
      wd_fault = 1'b0;
      nr_fault = 1'b0;
      wd_per = '0;
      ev = '0;
      want = '0;
      d = q;
      d.sleep_req = 1'b0;

      act = (mode_i == fmhs_pkg::MODE_NORMAL) || (mode_i == fmhs_pkg::MODE_NORMAL_REQ);
      low_pwr = (mode_i == fmhs_pkg::MODE_SLEEP) || (mode_i == fmhs_pkg::MODE_STOP);
      wr_high_side_control = reg_wr_i && hit(reg_addr_i, `FMHS_ADDR_HS_CONTROL);
      wr_mcr = reg_wr_i && hit(reg_addr_i, `FMHS_ADDR_MODE_CONTROL);
      wr_imr = reg_wr_i && hit(reg_addr_i, `FMHS_ADDR_INT_MASK);
      rd_lin = reg_rd_i && hit(reg_addr_i, `FMHS_ADDR_LIN_STATUS);
      rd_wd = reg_rd_i && hit(reg_addr_i, `FMHS_ADDR_WD_STATUS);
      rd_isr = reg_rd_i && hit(reg_addr_i, `FMHS_ADDR_INT_SOURCE);

      // Control writes
      if (wr_high_side_control) begin
         d.hs_ctrl = reg_wdata_i;
      end
      if (wr_mcr) begin
         d.high_voltage_shutdown_enable = reg_wdata_i[`FMHS_MCR_HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT];
      end
      if (wr_imr) begin
         d.int_mask = reg_wdata_i[2:0];
      end

      if (act) begin
         vs_ev = (ov && !q.supply[`FMHS_SUP_OV_BIT]) || (uv && !q.supply[`FMHS_SUP_UV_BIT]);
         d.supply[`FMHS_SUP_OV_BIT] = ov;
         d.supply[`FMHS_SUP_UV_BIT] = uv;
      end
      if (!low_pwr) begin
         vs_ev = vs_ev || (prewarn && !q.supply[`FMHS_SUP_PREWARN_BIT]);
         d.supply[`FMHS_SUP_PREWARN_BIT] = prewarn;
      end
      d.supply[`FMHS_SUP_BATTERY_FAIL_FLAG_BIT] = battery_fail_flag;

      if (wr_high_side_control && !ov) begin
         d.hs_hv_shut = 1'b0;
      end
      if ((mode_i == fmhs_pkg::MODE_NORMAL) && ov && q.high_voltage_shutdown_enable) begin
         d.hs_hv_shut = 1'b1;
      end
      if (wr_high_side_control && !hs_ot) begin
         d.hs_ot_shut = 1'b0;
      end
      if (hs_ot) begin
         hs_ev = !q.hs_ot_shut;
         d.hs_ot_shut = 1'b1;
      end
      want = q.hs_ctrl[1:0];
      for (int i = 0; i < 2; i++) begin
         if (q.hs_ctrl[i + 2]) begin
            want[i] = want[i] && pwm;
         end
      end
      // current limit does not turn off
      d.hs_out = want & {2{!d.hs_hv_shut && !d.hs_ot_shut}};

      if (txd) begin
         d.txd_cnt = '0;
      end else if (q.txd_cnt != W'(TXD_STUCK_CYC)) begin
         d.txd_cnt = q.txd_cnt + W'(1);
      end
      tx_stuck = (q.txd_cnt == W'(TXD_STUCK_CYC));
      lin_fault = rx_short || lin_ot || tx_stuck;
      if (rd_lin && !rx_short) begin
         d.lin_rx_short = 1'b0;
      end
      if (rd_lin && txd) begin
         d.lin_tx_stuck = 1'b0;
      end
      if (act) begin
         d.lin_ot = lin_ot;
         if (rx_short) begin
            d.lin_rx_short = 1'b1;
         end
         if (tx_stuck) begin
            d.lin_tx_stuck = 1'b1;
         end
      end
      if (act && lin_fault) begin
         lin_ev = !q.lin_shut;
         d.lin_shut = 1'b1;
      end else if (!lin_fault && txd) begin
         d.lin_shut = 1'b0;
      end

      irq_ok = act || (mode_i == fmhs_pkg::MODE_STOP);
      ev[`FMHS_IMR_SUPPLY_BIT] = vs_ev;
      ev[`FMHS_IMR_LIN_BIT] = lin_ev;
      ev[`FMHS_IMR_HS_BIT] = hs_ev;
      if (rd_isr) begin
         d.int_flags = '0;
      end
      if (irq_ok) begin
         d.int_flags = d.int_flags | (ev & q.int_mask);
      end

      wd_per = wd_float ? W'(WD_INT_CYC) : W'(WD_EXT_CYC);
      if (mode_i != fmhs_pkg::MODE_NORMAL) begin
         d.wd_cnt = '0;
      end else if (wr_mcr && reg_wdata_i[`FMHS_MCR_WDCLR_BIT]) begin
         wd_fault = (q.wd_cnt < (wd_per >> 1));
         d.wd_cnt = '0;
      end else if (q.wd_cnt >= wd_per - W'(1)) begin
         wd_fault = 1'b1;
         d.wd_cnt = '0;
      end else begin
         d.wd_cnt = q.wd_cnt + W'(1);
      end
      if (rd_wd) begin
         d.wd_timeout = 1'b0;
      end
      if (wd_fault) begin
         d.wd_timeout = 1'b1;
      end

      if (mode_i != fmhs_pkg::MODE_NORMAL_REQ) begin
         d.nr_cnt = '0;
      end else if (q.nr_cnt >= W'(NR_TIMEOUT_CYC - 1)) begin
         nr_fault = 1'b1;
         d.nr_cnt = '0;
      end else begin
         d.nr_cnt = q.nr_cnt + W'(1);
      end

      // Host reset sequencer
      case (q.seq)
         fmhs_pkg::SEQ_RUN: begin
            d.rst_cnt = '0;
            if (reg_ot && !q.reg_off) begin
               d.reg_off = 1'b1;
               d.ot_pend = 1'b1;
               d.seq = fmhs_pkg::SEQ_RESET;
            end else if (wd_fault || nr_fault) begin
               d.seq = fmhs_pkg::SEQ_RESET;
            end
         end
         fmhs_pkg::SEQ_RESET: begin
            d.rst_cnt = q.rst_cnt + W'(1);
            if (q.rst_cnt >= W'(RST_HOLD_CYC - 1)) begin
               d.seq = q.ot_pend ? fmhs_pkg::SEQ_SLEEP : fmhs_pkg::SEQ_RUN;
            end
         end
         fmhs_pkg::SEQ_SLEEP: begin
            d.sleep_req = 1'b1;
            d.ot_pend = 1'b0;
            d.seq = fmhs_pkg::SEQ_RUN;
         end
         default: begin
            d.seq = fmhs_pkg::SEQ_RUN;
         end
      endcase
      if ((mode_i == fmhs_pkg::MODE_SLEEP) && !reg_ot && !q.ot_pend) begin
         d.reg_off = 1'b0;
      end
      if ((mode_i == fmhs_pkg::MODE_RESET) && vdd_uv && !uv) begin
         d.sleep_req = 1'b1;
      end
      d.host_rst = (vdd_uv && (mode_i != fmhs_pkg::MODE_SLEEP))
         || (d.seq == fmhs_pkg::SEQ_RESET);

      // Register read data
      if (reg_rd_i) begin
         if (hit(reg_addr_i, `FMHS_ADDR_SUPPLY_STATUS)) begin
            d.rd_data = q.supply;
         end else if (rd_lin) begin
            d.rd_data = {q.lin_rx_short, q.lin_tx_stuck, q.lin_ot, 1'b0};
         end else if (hit(reg_addr_i, `FMHS_ADDR_HS_STATUS)) begin
            d.rd_data = q.hs_ot_shut ? 4'hf : {ol2, cl2, ol1, cl1};
         end else if (rd_wd) begin
            d.rd_data = {q.wd_timeout, wd_float, 2'h0};
         end else if (rd_isr) begin
            d.rd_data = src_code(q.int_flags);
         end else if (hit(reg_addr_i, `FMHS_ADDR_HS_CONTROL)) begin
            d.rd_data = q.hs_ctrl;
         end else if (hit(reg_addr_i, `FMHS_ADDR_MODE_CONTROL)) begin
            d.rd_data = {3'h0, q.high_voltage_shutdown_enable};
         end else if (hit(reg_addr_i, `FMHS_ADDR_INT_MASK)) begin
            d.rd_data = {1'b0, q.int_mask};
         end else begin
            d.rd_data = 4'h0;
         end
      end
   end

   // ==================================================================
   // State register
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.hs_ctrl <= `FMHS_HS_CONTROL_RST;
         q.int_mask <= `FMHS_INT_MASK_RST;
         q.high_voltage_shutdown_enable <= `FMHS_HIGH_VOLTAGE_SHUTDOWN_ENABLE_RST;
         q.seq <= fmhs_pkg::SEQ_RUN;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // Outputs
   assign reg_rdata_o = q.rd_data;
   assign lin_tx_enable_o = !q.lin_shut;
   assign output_one_on_o = q.hs_out[0];
   assign output_two_on_o = q.hs_out[1];
   assign irq_n_o = !(|q.int_flags);
   assign interrupt_source_o = src_code(q.int_flags);
   assign host_reset_o = q.host_rst;
   assign regulator_disable_o = q.reg_off;
   assign goto_sleep_o = q.sleep_req;

endmodule

/* include/fmhs_params.svh */
// Constants of the fault monitor and high side control block
`ifndef FMHS_PARAMS_SVH
`define FMHS_PARAMS_SVH

// =====================================================================
// Register addresses
`define FMHS_ADDR_SUPPLY_STATUS 4'h0
`define FMHS_ADDR_LIN_STATUS 4'h1
`define FMHS_ADDR_HS_STATUS 4'h2
`define FMHS_ADDR_WD_STATUS 4'h3
`define FMHS_ADDR_INT_SOURCE 4'h4
`define FMHS_ADDR_HS_CONTROL 4'h5
`define FMHS_ADDR_MODE_CONTROL 4'h6
`define FMHS_ADDR_INT_MASK 4'h7

// =====================================================================
// Field positions
`define FMHS_SUP_OV_BIT 3
`define FMHS_SUP_UV_BIT 2
`define FMHS_SUP_PREWARN_BIT 1
`define FMHS_SUP_BATTERY_FAIL_FLAG_BIT 0
`define FMHS_LIN_RECEIVE_PIN_SHORT_FLAG_BIT 3
`define FMHS_LIN_TXSTUCK_BIT 2
`define FMHS_LIN_OT_BIT 1
`define FMHS_WD_TIMEOUT_BIT 3
`define FMHS_WD_CFGERR_BIT 2
`define FMHS_MCR_HIGH_VOLTAGE_SHUTDOWN_ENABLE_BIT 0
`define FMHS_MCR_WDCLR_BIT 1
`define FMHS_IMR_SUPPLY_BIT 0
`define FMHS_IMR_LIN_BIT 1
`define FMHS_IMR_HS_BIT 2

// =====================================================================
// Interrupt source codes
`define FMHS_CODE_NONE 4'h0
`define FMHS_CODE_SUPPLY 4'h5
`define FMHS_CODE_LIN 4'h4
`define FMHS_CODE_HS 4'h2

// =====================================================================
// Reset values
`define FMHS_HS_CONTROL_RST 4'h0
`define FMHS_INT_MASK_RST 3'h0
`define FMHS_HIGH_VOLTAGE_SHUTDOWN_ENABLE_RST 1'b0

// =====================================================================
// Timing
`define FMHS_CLK_KHZ 25000
`define FMHS_TXD_STUCK_MS 1000
`define FMHS_NR_TIMEOUT_MS 150
`define FMHS_WD_INT_MS 150
`define FMHS_WD_EXT_MS 150
`define FMHS_RST_HOLD_MS 1
`define FMHS_CNT_W 25

`endif

/* include/fmhs_pkg.sv */
// Types of the fault monitor and high side control block
package fmhs_pkg;

   // ==================================================================
   // Operating mode of the chip, given by the mode logic
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_NORMAL_REQ,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESET
   } fmhs_mode_type;

   // ==================================================================
   // Host reset sequencer
   typedef enum logic [1:0] {
      SEQ_RUN,
      SEQ_RESET,
      SEQ_SLEEP
   } fmhs_seq_type;

   // ==================================================================
   // Complete state of the top module
   typedef struct packed {
      logic [3:0] supply;
      logic lin_rx_short;
      logic lin_tx_stuck;
      logic lin_ot;
      logic lin_shut;
      logic [3:0] hs_ctrl;
      logic high_voltage_shutdown_enable;
      logic [2:0] int_mask;
      logic [2:0] int_flags;
      logic hs_hv_shut;
      logic hs_ot_shut;
      logic [1:0] hs_out;
      logic wd_timeout;
      logic [24:0] txd_cnt;
      logic [24:0] nr_cnt;
      logic [24:0] wd_cnt;
      logic [24:0] rst_cnt;
      fmhs_seq_type seq;
      logic ot_pend;
      logic reg_off;
      logic sleep_req;
      logic host_rst;
      logic [3:0] rd_data;
   } fmhs_state_type;

endpackage

/* rtl/fmhs_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fmhs_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Asynchronous inputs and filtered result
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } fmhs_sync_state_type;

   fmhs_sync_state_type q, d;

   // ==================================================================
   // Next state: output moves only where stages two and three agree
   always_comb begin
      d = q;
      d.s1 = async_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.o = (q.s2 & ~(q.s2 ^ q.s3)) | (q.o & (q.s2 ^ q.s3));
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.o;

endmodule

/* verification/fmhs_checker.sv */
// Assertion checker for the fault monitor top module
`timescale 1ns/1ps
module fmhs_checker (
   // Clock, reset and mode
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire fmhs_pkg::fmhs_mode_type mode_i,
   // Register port
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [3:0] reg_rdata_o,
   // Monitors and pins
   input wire logic regulator_overheat_i,
   input wire logic regulator_under_voltage_i,
   input wire logic receive_pin_short_i,
   input wire logic high_side_overheat_i,
   input wire logic direct_pwm_input_i,
   // Outputs
   input wire logic lin_tx_enable_o,
   input wire logic output_one_on_o,
   input wire logic output_two_on_o,
   input wire logic irq_n_o,
   input wire logic [3:0] interrupt_source_o,
   input wire logic host_reset_o,
   input wire logic regulator_disable_o
);
   // ==================================================================
   // Cycles since the last control write or PWM edge
   logic pwm_q;
   logic [3:0] recent_q;
   always_ff @(posedge core_clk_i) begin
      pwm_q <= direct_pwm_input_i;
      if (srst_i) begin
         recent_q <= 4'hf;
      end else if ((reg_wr_i && reg_addr_i == 4'h5) || pwm_q != direct_pwm_input_i) begin
         recent_q <= 4'h0;
      end else if (recent_q != 4'hf) begin
         recent_q <= recent_q + 4'h1;
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   chk_irq_code_agree: assert property (
      irq_n_o == (interrupt_source_o == 4'h0)) else $error("irq line and code disagree");
   chk_code_read: assert property (
      reg_rd_i && reg_addr_i == 4'h4 |=> reg_rdata_o == $past(interrupt_source_o))
      else $error("source code read differs from output");
   chk_hs_heat_off: assert property (
      $rose(high_side_overheat_i) |-> ##[1:8] (!output_one_on_o && !output_two_on_o))
      else $error("switches not shut on overheat");
   chk_one_on_cause: assert property (
      $rose(output_one_on_o) |-> (recent_q < 4'ha || $past(reg_wr_i)))
      else $error("output one rose without cause");
   chk_two_on_cause: assert property (
      $rose(output_two_on_o) |-> (recent_q < 4'ha || $past(reg_wr_i)))
      else $error("output two rose without cause");
   chk_reg_heat_off: assert property (
      $rose(regulator_overheat_i) |-> ##[1:8] regulator_disable_o)
      else $error("regulator not disabled");
   chk_uv_host_reset: assert property (
      (regulator_under_voltage_i && mode_i != fmhs_pkg::MODE_SLEEP) [*8] |-> host_reset_o)
      else $error("no host reset on regulator undervoltage");
   chk_lin_short_off: assert property (
      $rose(receive_pin_short_i) && mode_i == fmhs_pkg::MODE_NORMAL |-> ##[1:8] !lin_tx_enable_o)
      else $error("transmitter not disabled");
   chk_rdata_holds: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data changed without read");
   chk_irq_mode_gate: assert property (
      $fell(irq_n_o) |-> $past(mode_i) inside {fmhs_pkg::MODE_NORMAL,
      fmhs_pkg::MODE_NORMAL_REQ, fmhs_pkg::MODE_STOP})
      else $error("interrupt raised in a quiet mode");
endmodule

bind fmhs_top fmhs_checker fmhs_checker_i (.core_clk_i, .srst_i, .mode_i, .reg_rd_i, .reg_wr_i,
   .reg_addr_i, .reg_rdata_o, .regulator_overheat_i, .regulator_under_voltage_i,
   .receive_pin_short_i, .high_side_overheat_i, .direct_pwm_input_i, .lin_tx_enable_o,
   .output_one_on_o, .output_two_on_o, .irq_n_o, .interrupt_source_o, .host_reset_o,
   .regulator_disable_o);

/* verification/fmhs_host_model.sv */
// Host microcontroller model: register accesses, transmit and PWM pins
`timescale 1ns/1ps
module fmhs_host_model (
   // Clock
   input wire logic core_clk_i,
   // Register port
   output logic reg_rd_o,
   output logic reg_wr_o,
   output logic [3:0] reg_addr_o,
   output logic [3:0] reg_wdata_o,
   input wire logic [3:0] reg_rdata_i,
   // Pins driven by the host
   output logic lin_txd_o,
   output logic pwm_o
);
   // ==================================================================
   // Accesses; idle address and data show the inverse of the last value
   initial begin
      reg_rd_o = 1'b0;
      reg_wr_o = 1'b0;
      reg_addr_o = 4'h0;
      reg_wdata_o = 4'h0;
      lin_txd_o = 1'b1;
      pwm_o = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge core_clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [3:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge core_clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      @(negedge core_clk_i);
      d = reg_rdata_i;
   endtask
   task automatic set_txd(input logic v);
      @(negedge core_clk_i);
      lin_txd_o = v;
   endtask
   task automatic set_pwm(input logic v);
      @(negedge core_clk_i);
      pwm_o = v;
   endtask
endmodule

/* verification/tb.sv */
// Self-checking testbench of the fault monitor and high side control
`timescale 1ns/1ps
module tb;
   // ==================================================================
   // Signals
   logic core_clk_i;
   logic srst_i;
   fmhs_pkg::fmhs_mode_type mode;
   logic rd_s, wr_s, txd, pwm, rxs, lot, hot, cl1, ol2, ruv, roh, wdf, bf, ol1, cl2;
   logic tx_en, o1, o2, irq_n, hrst, rdis, gsl;
   logic [2:0] sup;
   logic [3:0] addr, wdata, rdata, src;
   int num_errors = 0;
   int comparisons = 0;

   fmhs_top #(.TXD_STUCK_CYC(20), .NR_TIMEOUT_CYC(30), .WD_INT_CYC(16), .WD_EXT_CYC(24),
      .RST_HOLD_CYC(5)) fmhs_top_i (.core_clk_i, .srst_i, .mode_i(mode), .reg_rd_i(rd_s),
      .reg_wr_i(wr_s), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .supply_over_voltage_i(sup[2]), .supply_under_voltage_i(sup[1]), .battery_fail_i(bf),
      .regulator_prewarn_i(sup[0]), .regulator_overheat_i(roh), .regulator_under_voltage_i(ruv),
      .receive_pin_short_i(rxs), .lin_driver_overheat_i(lot), .lin_txd_i(txd),
      .lin_tx_enable_o(tx_en), .high_side_overheat_i(hot), .output_one_open_load_i(ol1),
      .output_two_open_load_i(ol2), .output_one_current_limit_i(cl1),
      .output_two_current_limit_i(cl2), .direct_pwm_input_i(pwm), .output_one_on_o(o1),
      .output_two_on_o(o2), .watchdog_config_pin_floating_i(wdf), .irq_n_o(irq_n),
      .interrupt_source_o(src), .host_reset_o(hrst), .regulator_disable_o(rdis),
      .goto_sleep_o(gsl));

   fmhs_host_model fmhs_host_model_i (.core_clk_i, .reg_rd_o(rd_s), .reg_wr_o(wr_s),
      .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .lin_txd_o(txd),
      .pwm_o(pwm));

   task automatic wt(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [3:0] e);
      logic [3:0] d;
      fmhs_host_model_i.rd(a, d);
      chk(d, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      fmhs_host_model_i.wr(a, d);
   endtask
   task automatic wait_sleep;
      int n;
      n = 0;
      while (gsl !== 1'b1 && n < 40) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      chk({3'h0, gsl}, 4'h1);
      wt(1);
   endtask
   task automatic end_sim;
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==================================================================
   // Scenarios
   task automatic t_reset;
      chk({irq_n, o1, o2, tx_en}, 4'h9);
      chk(src, 4'h0);
      rdc(4'h5, 4'h0);
      rdc(4'h7, 4'h0);
      rdc(4'h9, 4'h0);
   endtask
   task automatic t_ctrl;
      logic [7:0] tb_l [7];
      tb_l = '{8'h12, 8'h21, 8'h71, 8'h77, 8'hb7, 8'hb2, 8'hc4};
      for (int i = 0; i < 7; i++) begin
         wr(4'h5, tb_l[i][7:4]);
         fmhs_host_model_i.set_pwm(tb_l[i][2]);
         wt(8);
         chk({2'h0, o1, o2}, {2'h0, tb_l[i][1:0]});
      end
   endtask
   task automatic t_supply;
      for (int i = 0; i < 3; i++) begin
         wr(4'h7, 4'h0);
         sup = 3'b100 >> i;
         wt(8);
         chk({3'h0, irq_n}, 4'h1);
         rdc(4'h0, 4'h8 >> i);
         sup = 3'h0;
         wt(8);
         wr(4'h7, 4'h1);
         sup = 3'b100 >> i;
         wt(8);
         chk({3'h0, irq_n}, 4'h0);
         rdc(4'h4, 4'h5);
         chk({3'h0, irq_n}, 4'h1);
         sup = 3'h0;
         wt(8);
      end
   endtask
   task automatic t_hs;
      for (int i = 0; i < 2; i++) begin
         wr(4'h7, 4'h7);
         wr(4'h6, 4'h1);
         wr(4'h5, 4'h3);
         if (i == 0) sup = 3'b100;
         else hot = 1'b1;
         wt(8);
         chk({2'h0, o1, o2}, 4'h0);
         if (i == 1) rdc(4'h2, 4'hf);
         rdc(4'h4, (i == 1) ? 4'h2 : 4'h5);
         sup = 3'h0;
         hot = 1'b0;
         wt(8);
         chk({2'h0, o1, o2}, 4'h0);
         wr(4'h5, 4'h3);
         wt(3);
         chk({2'h0, o1, o2}, 4'h3);
      end
   endtask
   task automatic t_limit;
      cl1 = 1'b1;
      ol2 = 1'b1;
      bf = 1'b1;
      wt(8);
      chk({irq_n, 1'b0, o1, o2}, 4'hb);
      rdc(4'h2, 4'h9);
      rdc(4'h0, 4'h1);
      cl1 = 1'b0;
      ol2 = 1'b0;
      bf = 1'b0;
      ol1 = 1'b1;
      cl2 = 1'b1;
      wt(8);
      chk({irq_n, 1'b0, o1, o2}, 4'hb);
      rdc(4'h2, 4'h6);
      ol1 = 1'b0;
      cl2 = 1'b0;
      wt(8);
      rdc(4'h2, 4'h0);
   endtask
   task automatic t_lin;
      logic [3:0] ex [3];
      logic [3:0] d;
      ex = '{4'h8, 4'h2, 4'h4};
      for (int i = 0; i < 3; i++) begin
         if (i == 0) rxs = 1'b1;
         else if (i == 1) lot = 1'b1;
         else fmhs_host_model_i.set_txd(1'b0);
         wt((i == 2) ? 30 : 8);
         chk({3'h0, tx_en}, 4'h0);
         rdc(4'h1, ex[i]);
         rdc(4'h1, ex[i]);
         rdc(4'h4, 4'h4);
         rxs = 1'b0;
         lot = 1'b0;
         fmhs_host_model_i.set_txd(1'b1);
         wt(8);
         chk({3'h0, tx_en}, 4'h1);
         fmhs_host_model_i.rd(4'h1, d);
         rdc(4'h1, 4'h0);
      end
   endtask
   task automatic t_wdog;
      wdf = 1'b1;
      mode = fmhs_pkg::MODE_RESET;
      wt(8);
      // Earlier Normal-mode runs let the watchdog expire
      rdc(4'h3, 4'hc);
      rdc(4'h3, 4'h4);
      mode = fmhs_pkg::MODE_NORMAL;
      wt(2);
      wr(4'h6, 4'h3);
      wt(3);
      chk({3'h0, hrst}, 4'h1);
      rdc(4'h3, 4'hc);
      wdf = 1'b0;
   endtask
   task automatic t_modes;
      mode = fmhs_pkg::MODE_NORMAL_REQ;
      wt(28);
      chk({3'h0, hrst}, 4'h0);
      wt(4);
      chk({3'h0, hrst}, 4'h1);
      mode = fmhs_pkg::MODE_SLEEP;
      hot = 1'b1;
      wt(8);
      chk({irq_n, 1'b0, o1, o2}, 4'h8);
      hot = 1'b0;
      sup = 3'b100;
      wt(8);
      rdc(4'h0, 4'h0);
      sup = 3'h0;
      wt(8);
      mode = fmhs_pkg::MODE_NORMAL;
      wr(4'h5, 4'h3);
      wt(3);
      chk({irq_n, 1'b0, o1, o2}, 4'hb);
   endtask
   task automatic t_regul;
      roh = 1'b1;
      wt(8);
      chk({2'h0, rdis, hrst}, 4'h3);
      wait_sleep();
      roh = 1'b0;
      ruv = 1'b1;
      wt(8);
      chk({3'h0, hrst}, 4'h1);
      mode = fmhs_pkg::MODE_RESET;
      wait_sleep();
      ruv = 1'b0;
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end
   initial begin
      repeat (6000) @(posedge core_clk_i);
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 4'h0, 4'h1);
      end_sim();
   end
   initial begin
      srst_i = 1'b1;
      mode = fmhs_pkg::MODE_NORMAL;
      {sup, rxs, lot, hot, cl1, ol2, ruv, roh, wdf, bf, ol1, cl2} = 14'h0000;
      wt(2);
      srst_i = 1'b0;
      wt(4);
      t_reset();
      $display("reset test done");
      t_ctrl();
      $display("control test done");
      t_supply();
      $display("supply test done");
      t_hs();
      $display("shutdown test done");
      t_limit();
      $display("current limit test done");
      t_lin();
      $display("lin test done");
      t_wdog();
      $display("watchdog test done");
      t_modes();
      $display("mode test done");
      t_regul();
      $display("regulator test done");
      end_sim();
   end
endmodule
